//--- acqic_pkg.sv
// package of constants and types for the acquisition interrupt controller
package acqic_pkg;

   // ****************************************
   // register map and field layout
   // ****************************************
   localparam logic [3:0] ENABLE_WORD_ADDR = 4'h9;
   localparam logic [3:0] STATUS_WORD_ADDR = 4'ha;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   localparam int NUM_SRC = 8;
   localparam int TRIG_IP_LSB = 8;
   localparam int TRIG_IP_MSB = 10;
   localparam int FIFO_THR_LSB = 11;
   localparam int FIFO_THR_MSB = 15;
   localparam logic [4:0] FIFO_LEVEL_MAX = 5'h1f;

   // ****************************************
   // source numbers inside the flag vector
   // ****************************************
   localparam int SRC_WATCHDOG = 0;
   localparam int SRC_IP_MATCH = 1;
   localparam int SRC_FIFO_FILL = 2;
   localparam int SRC_SHORT_CAL = 3;
   localparam int SRC_FULL_CAL = 4;
   localparam int SRC_PAUSE = 5;
   localparam int SRC_LOW_SUPPLY = 6;
   localparam int SRC_WAKE = 7;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_FREQ_MHZ = 25;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS * CLK_FREQ_MHZ / 1000;
   localparam int WAKE_DELAY_MS = 10;
   localparam int WAKE_TICKS_DEF = WAKE_DELAY_MS * 1000000 / TICK_NS;
   localparam int CMP_LATENCY = 3;

   // ****************************************
   // state types
   // ****************************************
   typedef enum logic [1:0] {WK_IDLE = 2'b01, WK_WAIT = 2'b10} acqic_wake_t;
   typedef enum logic [2:0] {
      CMP_IDLE = 3'b001,
      CMP_LIM1 = 3'b010,
      CMP_LIM2 = 3'b100
   } acqic_cmp_t;

endpackage

//--- acqic_limit_cmp.sv
// watchdog limit comparator: two sequential comparisons of one held sample
`timescale 1ns/10ps
module acqic_limit_cmp (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmp_start,
   input wire logic signed [8:0] cmp_sample,
   input wire logic signed [8:0] lim1_value,
   input wire logic lim1_above,
   input wire logic signed [8:0] lim2_value,
   input wire logic lim2_above,
   output logic cmp_busy,
   output logic limit_hit
);
   import acqic_pkg::*;

   acqic_cmp_t state_reg, state_next;
   logic signed [8:0] sample_reg, sample_next;
   logic hit1_reg, hit1_next;
   logic hit_reg, hit_next;

   // direction flag picks above-limit or below-limit as the trip condition
   function automatic logic crossed(input logic signed [8:0] s, input logic signed [8:0] l,
                                    input logic above);
      crossed = above ? (s > l) : (s < l);
   endfunction

   // ****************************************
   // comparison sequence
   // ****************************************
   // sample is latched once so both limits see the very same value
   always_comb begin
      state_next = state_reg;
      sample_next = sample_reg;
      hit1_next = hit1_reg;
      hit_next = 1'b0;
      unique case (state_reg)
         CMP_IDLE: begin
            if (cmp_start) begin
               sample_next = cmp_sample;
               state_next = CMP_LIM1;
            end
         end
         CMP_LIM1: begin
            hit1_next = crossed(sample_reg, lim1_value, lim1_above);
            state_next = CMP_LIM2;
         end
         CMP_LIM2: begin
            hit_next = hit1_reg | crossed(sample_reg, lim2_value, lim2_above);
            state_next = CMP_IDLE;
         end
         default: state_next = CMP_IDLE;
      endcase
   end

   // registers only
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= CMP_IDLE;
         sample_reg <= 9'h000;
         hit1_reg <= 1'b0;
         hit_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sample_reg <= sample_next;
         hit1_reg <= hit1_next;
         hit_reg <= hit_next;
      end
   end

   assign cmp_busy = (state_reg != CMP_IDLE);
   assign limit_hit = hit_reg;

   // ****************************************
   // checks
   // ****************************************
   cmp_order_a: assert property (@(posedge mclk) disable iff (rst)
      (cmp_start && state_reg == CMP_IDLE) |=> state_reg == CMP_LIM1 ##1 state_reg == CMP_LIM2)
      else $error("comparator did not step through both limits");
   hit_pace_a: assert property (@(posedge mclk) disable iff (rst)
      limit_hit |-> $past(cmp_start, 3))
      else $error("limit hit without a start three cycles before");

endmodule

//--- acqic_interrupt_controller.sv
// interrupt controller: eight event flags, enable mask, active-low interrupt pin
`timescale 1ns/10ps
module acqic_interrupt_controller #(
   parameter int WAKE_TICKS = acqic_pkg::WAKE_TICKS_DEF
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic bus_width_sel,
   input wire logic [4:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   input wire logic dev_reset,
   input wire logic wd_start,
   input wire logic signed [8:0] wd_sample,
   input wire logic signed [8:0] wd_lim1,
   input wire logic wd_lim1_above,
   input wire logic signed [8:0] wd_lim2,
   input wire logic wd_lim2_above,
   input wire logic seq_restart,
   input wire logic seq_fetch,
   input wire logic [2:0] seq_ip,
   input wire logic seq_pause,
   input wire logic [5:0] fifo_count,
   input wire logic short_cal_done,
   input wire logic full_cal_done,
   input wire logic low_supply,
   input wire logic standby,
   output logic int_n
);
   import acqic_pkg::*;

   localparam int WK_W = $clog2(WAKE_TICKS + 1);
   localparam int DIV_W = $clog2(TICK_CYCLES + 1);

   // word decode shared by the read and write paths
   function automatic logic reg_hit(input logic [4:0] a, input logic [3:0] word);
      reg_hit = (a[4:1] == word);
   endfunction

   logic [15:0] en_reg, en_next;
   logic [7:0] flags_reg, flags_next;
   logic [15:0] rdata_reg, rdata_next;
   logic int_n_reg, int_n_next;
   logic first_fetch_reg, first_fetch_next;
   logic fifo_eq_reg, fifo_eq_next;
   logic standby_reg;
   acqic_wake_t wk_state_reg, wk_state_next;
   logic [WK_W-1:0] wk_cnt_reg, wk_cnt_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [7:0] set_vec;
   logic [2:0] trig_ip;
   logic [4:0] fifo_thr;
   logic [4:0] fifo_level;
   logic [15:0] status_word;
   logic wd_hit;
   logic wk_tick;
   logic wk_done;
   logic en_sel, st_sel, status_clr;
   logic pend;

   assign trig_ip = en_reg[TRIG_IP_MSB:TRIG_IP_LSB];
   assign fifo_thr = en_reg[FIFO_THR_MSB:FIFO_THR_LSB];

   // ****************************************
   // watchdog comparator
   // ****************************************
   acqic_limit_cmp acqic_limit_cmp_inst (
      .mclk(mclk),
      .rst(rst),
      .cmp_start(wd_start),
      .cmp_sample(wd_sample),
      .lim1_value(wd_lim1),
      .lim1_above(wd_lim1_above),
      .lim2_value(wd_lim2),
      .lim2_above(wd_lim2_above),
      .cmp_busy(),
      .limit_hit(wd_hit)
   );

   // ****************************************
   // wake-from-standby settling timer
   // ****************************************
   // a 1 us tick divider keeps the 10 ms counter narrow
   assign wk_tick = (div_reg == DIV_W'(TICK_CYCLES - 1));
   assign wk_done = (wk_state_reg == WK_WAIT) && wk_tick && (wk_cnt_reg == '0);

   always_comb begin
      wk_state_next = wk_state_reg;
      wk_cnt_next = wk_cnt_reg;
      div_next = wk_tick ? '0 : div_reg + DIV_W'(1);
      unique case (wk_state_reg)
         WK_IDLE: begin
            if (standby_reg && !standby) begin
               wk_state_next = WK_WAIT;
               wk_cnt_next = WK_W'(WAKE_TICKS - 1);
               div_next = '0;
            end
         end
         WK_WAIT: begin
            // going back into standby abandons the wait
            if (standby || wk_done) begin
               wk_state_next = WK_IDLE;
            end else if (wk_tick) begin
               wk_cnt_next = wk_cnt_reg - WK_W'(1);
            end
         end
         default: wk_state_next = WK_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wk_state_reg <= WK_IDLE;
         wk_cnt_reg <= '0;
         div_reg <= '0;
         standby_reg <= 1'b0;
      end else begin
         wk_state_reg <= wk_state_next;
         wk_cnt_reg <= wk_cnt_next;
         div_reg <= div_next;
         standby_reg <= standby;
      end
   end

   // ****************************************
   // event sources
   // ****************************************
   // fifo event is taken on the edge into equality so a read clear is not undone at once
   always_comb begin
      fifo_eq_next = (fifo_thr != 5'h00) && (fifo_count == {1'b0, fifo_thr});
      first_fetch_next = first_fetch_reg;
      if (seq_restart || dev_reset) begin
         first_fetch_next = 1'b1;
      end else if (seq_fetch && seq_ip == 3'h0) begin
         first_fetch_next = 1'b0;
      end
      set_vec = '0;
      set_vec[SRC_WATCHDOG] = wd_hit;
      set_vec[SRC_IP_MATCH] = seq_fetch && (seq_ip == trig_ip)
         && !(trig_ip == 3'h0 && first_fetch_reg);
      set_vec[SRC_FIFO_FILL] = fifo_eq_next && !fifo_eq_reg;
      set_vec[SRC_SHORT_CAL] = short_cal_done;
      set_vec[SRC_FULL_CAL] = full_cal_done;
      set_vec[SRC_PAUSE] = seq_fetch && seq_pause;
      set_vec[SRC_LOW_SUPPLY] = low_supply;
      set_vec[SRC_WAKE] = wk_done;
   end

   // ****************************************
   // register bus
   // ****************************************
   // byte mode uses A0 as byte select; a word status read or a low-byte status read clears flags
   assign en_sel = reg_hit(bus_addr, ENABLE_WORD_ADDR);
   assign st_sel = reg_hit(bus_addr, STATUS_WORD_ADDR);
   assign status_clr = bus_rd && st_sel && (!bus_width_sel || !bus_addr[0]);
   assign fifo_level = (fifo_count > 6'h1f) ? FIFO_LEVEL_MAX : fifo_count[4:0];
   assign status_word = {fifo_level, seq_ip, flags_reg};

   always_comb begin
      en_next = en_reg;
      rdata_next = rdata_reg;
      if (bus_wr && en_sel) begin
         if (!bus_width_sel) begin
            en_next = bus_wdata;
         end else if (!bus_addr[0]) begin
            en_next[7:0] = bus_wdata[7:0];
         end else begin
            en_next[15:8] = bus_wdata[7:0];
         end
      end
      if (bus_rd) begin
         rdata_next = en_sel ? en_reg : (st_sel ? status_word : RDATA_RESET);
         if (bus_width_sel) begin
            rdata_next = {8'h00, bus_addr[0] ? rdata_next[15:8] : rdata_next[7:0]};
         end
      end
   end

   // ****************************************
   // flags and interrupt pin
   // ****************************************
   // a set in the clearing cycle survives; masking never blocks a set
   always_comb begin
      flags_next = (flags_reg & ~{8{status_clr}}) | set_vec;
      if (dev_reset) begin
         flags_next = FLAGS_RESET;
      end
      // pin is purely an output; nothing here reaches the sequencer control
      int_n_next = ~|(flags_next & en_next[NUM_SRC-1:0]);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         en_reg <= ENABLE_RESET;
         flags_reg <= FLAGS_RESET;
         rdata_reg <= RDATA_RESET;
         int_n_reg <= 1'b1;
         first_fetch_reg <= 1'b1;
         fifo_eq_reg <= 1'b0;
      end else begin
         en_reg <= en_next;
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
         int_n_reg <= int_n_next;
         first_fetch_reg <= first_fetch_next;
         fifo_eq_reg <= fifo_eq_next;
      end
   end

   assign bus_rdata = rdata_reg;
   assign int_n = int_n_reg;
   assign pend = |(flags_reg & en_reg[NUM_SRC-1:0]);

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   int_pin_match_a: assert property (int_n == !pend)
      else $error("interrupt pin disagrees with pending flags");
   flag_set_a: assert property ((|set_vec) && !dev_reset |=>
      (flags_reg & $past(set_vec)) == $past(set_vec))
      else $error("event did not set its flag");
   status_clear_a: assert property (status_clr && !dev_reset |=>
      (flags_reg & ~$past(set_vec)) == 8'h00)
      else $error("status read left flags set");
   dev_reset_clear_a: assert property (dev_reset |=> flags_reg == 8'h00)
      else $error("device reset did not clear flags");
   ip_match_a: assert property (seq_fetch && seq_ip == trig_ip && trig_ip != 3'h0
      && !dev_reset |=> flags_reg[SRC_IP_MATCH])
      else $error("pointer match not flagged");
   // watched on the flag register so a broken skip shows where the host looks
   first_fetch_a: assert property (seq_fetch && seq_ip == 3'h0 && trig_ip == 3'h0
      && first_fetch_reg && !flags_reg[SRC_IP_MATCH] |=> !flags_reg[SRC_IP_MATCH])
      else $error("first fetch of instruction zero flagged");
   fifo_thr_a: assert property ($rose(fifo_eq_reg) && !$past(dev_reset) |->
      flags_reg[SRC_FIFO_FILL])
      else $error("fifo threshold reached without flag");
   zero_thr_a: assert property (fifo_thr == 5'h00 && !flags_reg[SRC_FIFO_FILL] |=>
      !flags_reg[SRC_FIFO_FILL])
      else $error("zero fifo threshold raised a flag");
   wake_early_a: assert property ($fell(standby) |-> ##1 (!set_vec[SRC_WAKE])[*8])
      else $error("wake flag raised before settling delay");
   status_ip_a: assert property (bus_rd && st_sel && !bus_width_sel |=>
      bus_rdata[10:8] == $past(seq_ip) && bus_rdata[15:11] == $past(fifo_level))
      else $error("status read lost pointer or count");

   // bus side: a word write lands whole, read data holds, a high-byte read keeps flags
   en_write_a: assert property (bus_wr && en_sel && !bus_width_sel |=>
      en_reg == $past(bus_wdata))
      else $error("enable write did not land");
   rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data moved without a read");
   byte_keep_a: assert property (bus_rd && st_sel && bus_width_sel && bus_addr[0]
      && !dev_reset |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
      else $error("high byte status read cleared flags");

   // each of these five sources lands in its own bit, which catches a crossed flag map
   wd_flag_a: assert property (wd_hit && !dev_reset |=> flags_reg[SRC_WATCHDOG])
      else $error("watchdog hit not flagged");
   short_cal_a: assert property (short_cal_done && !dev_reset |=>
      flags_reg[SRC_SHORT_CAL])
      else $error("short calibration not flagged");
   full_cal_a: assert property (full_cal_done && !dev_reset |=>
      flags_reg[SRC_FULL_CAL])
      else $error("full calibration not flagged");
   pause_flag_a: assert property (seq_fetch && seq_pause && !dev_reset |=>
      flags_reg[SRC_PAUSE])
      else $error("pause fetch not flagged");
   low_supply_a: assert property (low_supply && !dev_reset |=>
      flags_reg[SRC_LOW_SUPPLY])
      else $error("low supply not flagged");

   // covers for the main scenarios
   int_pin_c: cover property ($fell(int_n));
   wake_flag_c: cover property (set_vec[SRC_WAKE]);
   clear_race_c: cover property (status_clr && (|set_vec));
   fifo_fill_c: cover property (set_vec[SRC_FIFO_FILL]);
   ip_skip_c: cover property (seq_fetch && seq_ip == 3'h0 && trig_ip == 3'h0
      && first_fetch_reg);

endmodule

//--- acqic_host_model.sv
// host processor model that reaches the interrupt registers over the parallel bus
`timescale 1ns/10ps
module acqic_host_model (
   input wire logic mclk,
   output logic bus_width_sel,
   output logic [4:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata
);
   // bus idles with strobes low from time zero
   initial begin
      bus_width_sel = 1'b0;
      bus_addr = 5'h00;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 16'h0000;
   end

   // one-cycle read strobe; data is taken just after the following edge
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      bus_addr <= ~a; // released address does not keep its old value
      #1;
      d = bus_rdata;
   endtask

   // one-cycle write strobe; an enable write is followed by a status read
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] junk;
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
      if (a[4:1] == 4'h9) begin
         rd(5'h14, junk);
      end
   endtask

   // bus width is a board strap; it only changes between transfers
   task automatic set_bw(input logic b);
      @(posedge mclk);
      bus_width_sel <= b;
   endtask
endmodule

//--- acq_interrupt_controller_tb.sv
// self-checking testbench for the acquisition interrupt controller
`timescale 1ns/10ps
module acq_interrupt_controller_tb;
   import acqic_pkg::*;
   logic mclk, rst, dev_reset, wd_start, wd_lim1_above, wd_lim2_above, seq_restart;
   logic seq_fetch, seq_pause, short_cal_done, full_cal_done, low_supply, standby, int_n;
   logic signed [8:0] wd_sample, wd_lim1, wd_lim2;
   logic [2:0] seq_ip;
   logic [5:0] fifo_count;
   logic bus_width_sel, bus_rd, bus_wr;
   logic [4:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata;
   int n_mismatch = 0;
   int tests_run = 0;

   acqic_interrupt_controller #(.WAKE_TICKS(3)) acqic_interrupt_controller_inst (
      .mclk(mclk), .rst(rst), .bus_width_sel(bus_width_sel), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .dev_reset(dev_reset), .wd_start(wd_start), .wd_sample(wd_sample), .wd_lim1(wd_lim1),
      .wd_lim1_above(wd_lim1_above), .wd_lim2(wd_lim2), .wd_lim2_above(wd_lim2_above),
      .seq_restart(seq_restart), .seq_fetch(seq_fetch), .seq_ip(seq_ip),
      .seq_pause(seq_pause), .fifo_count(fifo_count), .short_cal_done(short_cal_done),
      .full_cal_done(full_cal_done), .low_supply(low_supply), .standby(standby),
      .int_n(int_n));

   acqic_host_model acqic_host_model_inst (
      .mclk(mclk), .bus_width_sel(bus_width_sel), .bus_addr(bus_addr), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   // status word expected from live pointer, saturated count and given flags
   task automatic chk_st(input logic [7:0] f, input string m);
      logic [15:0] d;
      acqic_host_model_inst.rd(5'h14, d);
      chk(d, {(fifo_count > 6'd31) ? 5'h1f : fifo_count[4:0], seq_ip, f}, m);
   endtask

   task automatic en_wr(input logic [15:0] v);
      acqic_host_model_inst.wr(5'h12, v);
   endtask

   // one-cycle pulse on an event or control input, then time for the flag to land
   task automatic fire(input int s);
      @(posedge mclk);
      case (s)
         3: short_cal_done <= 1'b1;
         4: full_cal_done <= 1'b1;
         5: begin
            seq_fetch <= 1'b1;
            seq_pause <= 1'b1;
         end
         6: low_supply <= 1'b1;
         8: seq_restart <= 1'b1;
         9: seq_fetch <= 1'b1;
         default: dev_reset <= 1'b1;
      endcase
      @(posedge mclk);
      {short_cal_done, full_cal_done, seq_fetch, seq_pause} <= 4'h0;
      {low_supply, seq_restart, dev_reset} <= 3'h0;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      logic [15:0] d;
      chk({15'h0, int_n}, 16'h1, "pin after reset");
      acqic_host_model_inst.rd(5'h12, d);
      chk(d, 16'h0000, "enable reset");
      en_wr(16'ha5c3);
      acqic_host_model_inst.wr(5'h14, 16'hffff); // status is read-only
      acqic_host_model_inst.rd(5'h12, d);
      chk(d, 16'ha5c3, "enable readback");
      acqic_host_model_inst.rd(5'h06, d);
      chk(d, 16'h0000, "unmapped read");
      acqic_host_model_inst.set_bw(1'b1);
      acqic_host_model_inst.rd(5'h13, d);
      chk(d, 16'h00a5, "byte high");
      acqic_host_model_inst.rd(5'h12, d);
      chk(d, 16'h00c3, "byte low");
      acqic_host_model_inst.wr(5'h13, 16'h003c);
      acqic_host_model_inst.rd(5'h13, d);
      chk(d, 16'h003c, "byte write high");
      acqic_host_model_inst.set_bw(1'b0);
   endtask

   // each simple source sets its flag, drives the pin, and a read clears both
   task automatic t_sources();
      en_wr(16'h00ff);
      for (int s = 3; s < 7; s++) begin
         fire(s);
         chk({15'h0, int_n}, 16'h0, "pin not low");
         chk_st(8'h01 << s, "source flag");
         chk({15'h0, int_n}, 16'h1, "pin not released");
      end
   endtask

   // a masked source still flags but leaves the pin alone
   task automatic t_mask();
      logic [15:0] d;
      en_wr(16'h0008);
      fire(4);
      chk({15'h0, int_n}, 16'h1, "masked drove pin");
      chk_st(8'h10, "masked flag");
      fire(3);
      chk({15'h0, int_n}, 16'h0, "enabled pin");
      acqic_host_model_inst.set_bw(1'b1);
      acqic_host_model_inst.rd(5'h15, d);
      chk(d, {8'h00, 5'h00, seq_ip}, "status high byte");
      acqic_host_model_inst.set_bw(1'b0);
      chk({15'h0, int_n}, 16'h0, "high byte read cleared");
      fire(5);
      fire(10);
      chk({15'h0, int_n}, 16'h1, "pin after dev reset");
      chk_st(8'h00, "flags after dev reset");
   endtask

   task automatic t_wd(input logic signed [8:0] s, input logic a1, input logic a2,
                       input logic [7:0] f);
      @(posedge mclk);
      wd_sample <= s;
      wd_lim1_above <= a1;
      wd_lim2_above <= a2;
      wd_start <= 1'b1;
      @(posedge mclk);
      wd_start <= 1'b0;
      repeat (6) @(posedge mclk);
      chk_st(f, "watchdog");
   endtask

   task automatic t_ip();
      en_wr(16'h0002);
      @(posedge mclk);
      seq_ip <= 3'h0;
      fire(8);
      fire(9);
      chk_st(8'h00, "first fetch of zero");
      fire(9);
      chk_st(8'h02, "second fetch of zero");
      en_wr(16'h0502);
      @(posedge mclk);
      seq_ip <= 3'h5;
      fire(9);
      chk_st(8'h02, "pointer match");
      @(posedge mclk);
      seq_ip <= 3'h7;
   endtask

   task automatic t_fifo();
      @(posedge mclk);
      fifo_count <= 6'd3;
      en_wr(16'h2704);
      @(posedge mclk);
      fifo_count <= 6'd4;
      repeat (3) @(posedge mclk);
      #1;
      chk({15'h0, int_n}, 16'h0, "fifo pin");
      chk_st(8'h04, "fifo flag");
      @(posedge mclk);
      fifo_count <= 6'd40;
      repeat (2) @(posedge mclk);
      chk_st(8'h00, "count saturates");
      en_wr(16'h0004);
      @(posedge mclk);
      fifo_count <= 6'd0;
      repeat (2) @(posedge mclk);
      chk_st(8'h00, "zero threshold");
   endtask

   task automatic t_wake();
      @(posedge mclk);
      standby <= 1'b1;
      repeat (3) @(posedge mclk);
      standby <= 1'b0;
      repeat (60) @(posedge mclk);
      chk_st(8'h00, "wake too early");
      repeat (20) @(posedge mclk);
      chk_st(8'h80, "wake flag");
   endtask

   // ****************************************
   // clock, reset, sequence and watchdog
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial begin
      #(40 * 5000);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      {dev_reset, wd_start, wd_lim1_above, wd_lim2_above, seq_restart} = 5'h00;
      {seq_fetch, seq_pause, short_cal_done, full_cal_done, low_supply, standby} = 6'h00;
      wd_sample = 9'sh000;
      wd_lim1 = 9'sh00a;
      wd_lim2 = -9'sh005;
      seq_ip = 3'h7;
      fifo_count = 6'h00;
      rst = 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_sources();
      t_mask();
      t_wd(9'sh014, 1'b1, 1'b1, 8'h01);
      t_wd(9'sh000, 1'b1, 1'b0, 8'h00);
      t_wd(-9'sh00a, 1'b1, 1'b0, 8'h01);
      t_wd(9'sh014, 1'b0, 1'b0, 8'h00);
      t_ip();
      t_fifo();
      t_wake();
      end_of_test();
   end
endmodule
